// File: src/sock_evt_pkg.sv
// constants shared by the socket status-change event block
package sock_evt_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] socket_change_flags_off = 8'h00;
  localparam logic [7:0] socket_change_irq_enables_off = 8'h04;
  localparam int data_w = 32;
  localparam int addr_w = 8;
  localparam int impl_w = 4;
  localparam logic [31:0] socket_change_flags_rst = 32'h0000_0000;
  localparam logic [31:0] socket_change_irq_enables_rst = 32'h0000_0000;
  // ==========================================================
  // field positions, shared by the flag, enable and force words
  localparam int card_status_bit = 0;
  localparam int detect_one_bit = 1;
  localparam int detect_two_bit = 2;
  localparam int power_cycle_bit = 3;
  localparam logic [1:0] insertion_irq_on = 2'h3;
  localparam logic [3:0] flags_clear = 4'h0;
  // synchroniser reset: three reset pins released (high), all else low
  localparam logic [8:0] pin_sync_rst = 9'h1C0;
endpackage

// File: src/socket_status_change_event_mask.sv
// socket status-change event flags, interrupt enables and interrupt request
`timescale 1ns/10ps
`default_nettype none

// Contract
// RULE1 - flags record only that a change happened, never the new value
// RULE2 - writing 1 to a flag clears it; writing 0 leaves it
// RULE3 - writing 1 to a force-event bit sets the matching flag
// RULE4 - bus reset clears every flag; the code clears them on bus reset only while pme_en is low
// RULE5 - leaving card reset re-sets flags when status is still present
// RULE6 - with interrupts enabled, any set unmasked flag raises the interrupt
// RULE7 - software clears all flags before enabling interrupts
// RULE8 - flag 3 sets when power-cycle status changes
// RULE9 - flag 2 sets when card-detect two status changes
// RULE10 - flag 1 sets when card-detect one status changes
// RULE11 - cardbus card: flag 0 sets on rising status-change edge only
// RULE12 - 16-bit card: flag 0 sets on both status-change edges
// RULE13 - bits 31 to 4 of both registers read zero
// RULE14 - enables never stop flags from being set
// RULE15 - enable bit 3 gates power-cycle interrupts, resets to 0
// RULE16 - enable field 2:1 is 00 block, 11 enable, others reserved
// RULE17 - enable bit 0 gates card-status interrupts, resets to 0
// RULE18 - with power-event signalling only global reset clears, else either reset
// RULE19 - flags low four bits write-one-to-clear, rest read-only, reset zero
// RULE20 - force-event writes show in the present state watched for changes
// RULE21 - interrupt is OR of flag AND enable, detect flags gated by field
module socket_status_change_event_mask (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // socket resets and power-event mode (pins)
  input wire logic global_reset_n_in,
  input wire logic bus_reset_n_in,
  input wire logic card_reset_n_in,
  input wire logic pme_enable_in,
  // socket status (pins)
  input wire logic socket_power_cycle_status_in,
  input wire logic card_detect_one_status_in,
  input wire logic card_detect_two_status_in,
  input wire logic card_status_change_state_in,
  input wire logic cardbus_card_in,
  // register port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [sock_evt_pkg::addr_w-1:0] reg_addr_in,
  input wire logic [sock_evt_pkg::data_w-1:0] reg_wdata_in,
  output logic [sock_evt_pkg::data_w-1:0] reg_rdata_out,
  // force-event write from the neighbouring register
  input wire logic force_wr_in,
  input wire logic [sock_evt_pkg::impl_w-1:0] force_data_in,
  // interrupt enable and request
  input wire logic irq_global_enable_in,
  output logic [sock_evt_pkg::impl_w-1:0] present_state_out,
  output logic status_change_interrupt_out
);
  import sock_evt_pkg::*;

  // ==========================================================
  // pin synchronisers
  localparam int n_sync = 9;
  logic [n_sync-1:0] sync1_r;
  logic [n_sync-1:0] sync2_r;
  // reset pins idle high and status pins idle low, so reset makes no false change
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_r <= pin_sync_rst;
    end else begin
      sync1_r <= {global_reset_n_in, bus_reset_n_in, card_reset_n_in, pme_enable_in,
                  cardbus_card_in, card_status_change_state_in,
                  card_detect_two_status_in, card_detect_one_status_in,
                  socket_power_cycle_status_in};
    end
  end

  // only this second stage is read by the logic below
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync2_r <= pin_sync_rst;
    end else begin
      sync2_r <= sync1_r;
    end
  end

  logic glob_rst_n;
  logic bus_rst_n;
  logic card_rst_n;
  logic pme_en;
  logic is_cardbus;
  logic [impl_w-1:0] pins;
  assign glob_rst_n = sync2_r[8];
  assign bus_rst_n = sync2_r[7];
  assign card_rst_n = sync2_r[6];
  assign pme_en = sync2_r[5];
  assign is_cardbus = sync2_r[4];
  assign pins = {sync2_r[0], sync2_r[2], sync2_r[1], sync2_r[3]};

  // context bits survive a bus reset while power events are signalled
  logic ctx_clear;
  assign ctx_clear = !glob_rst_n || (!bus_rst_n && !pme_en); // RULE4 RULE18

  // ==========================================================
  // present state: pin levels plus bits forced by software
  logic [impl_w-1:0] force_hold_r;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      force_hold_r <= flags_clear;
    end else if (ctx_clear) begin
      force_hold_r <= flags_clear;
    end else if (force_wr_in) begin
      force_hold_r <= force_data_in; // RULE20
    end
  end

  // forced bits are ORed in, so software can fake a socket change
  logic [impl_w-1:0] present_r;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      present_r <= flags_clear;
    end else begin
      present_r <= pins | force_hold_r; // RULE20
    end
  end

  // previous present state, the reference for change detection
  logic [impl_w-1:0] present_d_r;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      present_d_r <= flags_clear;
    end else begin
      present_d_r <= present_r;
    end
  end

  // resets to the released level so reset itself is not seen as leaving card reset
  logic card_rst_d_r;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      card_rst_d_r <= 1'b1;
    end else begin
      card_rst_d_r <= card_rst_n;
    end
  end

  // ==========================================================
  // change detection, only the fact of a change is kept
  logic [impl_w-1:0] changed;
  logic [impl_w-1:0] set_ev;
  logic leave_card_rst;
  logic status_rise;
  logic status_fall;
  assign changed = present_r ^ present_d_r; // RULE1
  assign leave_card_rst = card_rst_n && !card_rst_d_r;
  assign status_rise = changed[card_status_bit] && present_r[card_status_bit];
  assign status_fall = changed[card_status_bit] && !present_r[card_status_bit];
  always_comb begin
    set_ev = flags_clear;
    set_ev[power_cycle_bit] = changed[power_cycle_bit]; // RULE8
    set_ev[detect_two_bit] = changed[detect_two_bit]; // RULE9
    set_ev[detect_one_bit] = changed[detect_one_bit]; // RULE10
    if (is_cardbus) begin
      // a falling status line is ignored for this card type
      set_ev[card_status_bit] = status_rise; // RULE11
    end else begin
      set_ev[card_status_bit] = status_rise || status_fall; // RULE12
    end
    // status still present after card reset is reported again
    if (leave_card_rst) begin
      set_ev[card_status_bit] = set_ev[card_status_bit] | present_r[card_status_bit]; // RULE5
      set_ev[detect_one_bit] = set_ev[detect_one_bit] | present_r[detect_one_bit]; // RULE5
      set_ev[detect_two_bit] = set_ev[detect_two_bit] | present_r[detect_two_bit]; // RULE5
    end
    if (force_wr_in) begin
      set_ev = set_ev | force_data_in; // RULE3
    end
  end

  // ==========================================================
  // flag and enable registers
  logic flags_wr;
  logic en_wr;
  assign flags_wr = reg_wr_in && (reg_addr_in == socket_change_flags_off);
  assign en_wr = reg_wr_in && (reg_addr_in == socket_change_irq_enables_off);

  // clear request per flag; bits above the implemented four are dropped
  logic [impl_w-1:0] clr_ev;
  assign clr_ev = flags_wr ? reg_wdata_in[impl_w-1:0] : flags_clear; // RULE2 RULE19

  logic [impl_w-1:0] flags_r;
  logic [impl_w-1:0] flags_nxt;
  always_comb begin
    flags_nxt = flags_r & ~clr_ev; // RULE2
    // a set arriving with the clear wins; enables play no part here
    flags_nxt = flags_nxt | set_ev; // RULE14
  end

  // one register per flag, so each source has its own reset and update path
  logic card_status_change_flag_r;
  logic detect_one_change_flag_r;
  logic detect_two_change_flag_r;
  logic power_cycle_change_flag_r;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      card_status_change_flag_r <= socket_change_flags_rst[card_status_bit]; // RULE19
    end else if (ctx_clear) begin
      card_status_change_flag_r <= 1'b0; // RULE4 RULE18
    end else begin
      card_status_change_flag_r <= flags_nxt[card_status_bit];
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      detect_one_change_flag_r <= socket_change_flags_rst[detect_one_bit]; // RULE19
    end else if (ctx_clear) begin
      detect_one_change_flag_r <= 1'b0; // RULE4 RULE18
    end else begin
      detect_one_change_flag_r <= flags_nxt[detect_one_bit];
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      detect_two_change_flag_r <= socket_change_flags_rst[detect_two_bit]; // RULE19
    end else if (ctx_clear) begin
      detect_two_change_flag_r <= 1'b0; // RULE4 RULE18
    end else begin
      detect_two_change_flag_r <= flags_nxt[detect_two_bit];
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      power_cycle_change_flag_r <= socket_change_flags_rst[power_cycle_bit]; // RULE19
    end else if (ctx_clear) begin
      power_cycle_change_flag_r <= 1'b0; // RULE4 RULE18
    end else begin
      power_cycle_change_flag_r <= flags_nxt[power_cycle_bit];
    end
  end

  assign flags_r = {power_cycle_change_flag_r, detect_two_change_flag_r,
                    detect_one_change_flag_r, card_status_change_flag_r};

  // enables: bit 3 power cycle, field 2:1 card detect, bit 0 card status
  logic power_cycle_irq_enable_r;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      power_cycle_irq_enable_r <= socket_change_irq_enables_rst[power_cycle_bit]; // RULE15
    end else if (ctx_clear) begin
      power_cycle_irq_enable_r <= 1'b0; // RULE18
    end else if (en_wr) begin
      power_cycle_irq_enable_r <= reg_wdata_in[power_cycle_bit]; // RULE15
    end
  end

  logic [1:0] insertion_irq_enable_field_r;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      insertion_irq_enable_field_r <= socket_change_irq_enables_rst[detect_two_bit:detect_one_bit];
    end else if (ctx_clear) begin
      insertion_irq_enable_field_r <= 2'h0; // RULE18
    end else if (en_wr) begin
      insertion_irq_enable_field_r <= reg_wdata_in[detect_two_bit:detect_one_bit]; // RULE16
    end
  end

  logic card_status_irq_enable_r;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      card_status_irq_enable_r <= socket_change_irq_enables_rst[card_status_bit]; // RULE17
    end else if (ctx_clear) begin
      card_status_irq_enable_r <= 1'b0; // RULE18
    end else if (en_wr) begin
      card_status_irq_enable_r <= reg_wdata_in[card_status_bit]; // RULE17
    end
  end

  logic [impl_w-1:0] enables_r;
  assign enables_r = {power_cycle_irq_enable_r, insertion_irq_enable_field_r,
                      card_status_irq_enable_r};

  // ==========================================================
  // read data, upper bits always zero
  // the word is built apart from the strobe; the port loads it whole
  logic [data_w-1:0] rd_word;
  always_comb begin
    rd_word = '0;
    case (reg_addr_in)
      socket_change_flags_off: begin
        rd_word = {{(data_w-impl_w){1'b0}}, flags_r}; // RULE13
      end
      socket_change_irq_enables_off: begin
        rd_word = {{(data_w-impl_w){1'b0}}, enables_r}; // RULE13
      end
      default: begin
        rd_word = '0; // RULE19
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_word;
    end
  end

  // ==========================================================
  // interrupt request; reserved field codes 01/10 simply block
  logic detect_en;
  logic power_term;
  logic detect_term;
  logic status_term;
  logic irq_req;
  assign detect_en = (insertion_irq_enable_field_r == insertion_irq_on); // RULE16
  assign power_term = power_cycle_change_flag_r && power_cycle_irq_enable_r; // RULE15
  assign detect_term = (detect_two_change_flag_r || detect_one_change_flag_r)
                    && detect_en; // RULE21
  assign status_term = card_status_change_flag_r && card_status_irq_enable_r; // RULE17
  assign irq_req = power_term || detect_term || status_term; // RULE21

  // level request, one cycle behind its cause; gated by the global enable
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_change_interrupt_out <= 1'b0;
    end else begin
      status_change_interrupt_out <= irq_req && irq_global_enable_in; // RULE6
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      present_state_out <= flags_clear;
    end else begin
      present_state_out <= present_r;
    end
  end

endmodule // socket_status_change_event_mask

`default_nettype wire

// File: dv/card_model.sv
// card-side model that drives the socket status pins
`timescale 1ns/10ps
`default_nettype none
module card_model (
  // 4 cardbus, 3 power, 2 detect two, 1 detect one, 0 status change
  output logic [4:0] pins_out
);
  initial pins_out = 5'h00;
  // levels change when drive is called, with no clock of their own, and hold until the next command
  task automatic drive(input logic [4:0] v);
    pins_out <= v;
  endtask
endmodule // card_model
`default_nettype wire

// File: dv/socket_status_change_event_mask_properties.sv
// port-level checker for the socket status-change event block
`timescale 1ns/10ps
`default_nettype none
module sock_evt_checker (
  // ports watched
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic force_wr_in,
  input wire logic [3:0] force_data_in,
  input wire logic [3:0] present_state_out,
  input wire logic irq_global_enable_in,
  input wire logic status_change_interrupt_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_en_wr; reg_wr_in && reg_addr_in == 8'h04; endsequence
  sequence s_en_rd; reg_rd_in && !reg_wr_in && reg_addr_in == 8'h04; endsequence
  sequence s_off; reg_wr_in && reg_addr_in == 8'h04 && reg_wdata_in[3:0] == 4'h0; endsequence
  property p_rd_upper; reg_rd_in |=> reg_rdata_out[31:4] == 28'h0; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper bits not zero");
  property p_unmapped;
    reg_rd_in && reg_addr_in != 8'h00 && reg_addr_in != 8'h04 |=> reg_rdata_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_hold; !reg_rd_in |=> $stable(reg_rdata_out); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_en_back;
    s_en_wr ##2 s_en_rd |=> reg_rdata_out == {28'h0, $past(reg_wdata_in[3:0], 3)};
  endproperty
  a_en_back: assert property (p_en_back) else $error("enable readback");
  property p_force;
    force_wr_in ##1 !force_wr_in |=> ##1
      (present_state_out & $past(force_data_in, 3)) == $past(force_data_in, 3);
  endproperty
  a_force: assert property (p_force) else $error("forced bit not present");
  property p_gate; !irq_global_enable_in |=> !status_change_interrupt_out; endproperty
  a_gate: assert property (p_gate) else $error("interrupt while disabled");
  property p_off; s_off |=> ##1 !status_change_interrupt_out; endproperty
  a_off: assert property (p_off) else $error("interrupt with enables off");
  property p_rise;
    $rose(status_change_interrupt_out) |-> $past(irq_global_enable_in)
      && !$past(reg_wr_in && reg_addr_in == 8'h04 && reg_wdata_in[3:0] == 4'h0, 2);
  endproperty
  a_rise: assert property (p_rise) else $error("interrupt rise without cause");
endmodule // sock_evt_checker
bind socket_status_change_event_mask sock_evt_checker u_chk (.*);
`default_nettype wire

// File: dv/socket_status_change_event_mask_bench.sv
// self-checking bench for the socket status-change event block
`timescale 1ns/10ps
`default_nettype none
module socket_status_change_event_mask_bench;
  logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, fw = 1'h0, ien = 1'h0, pme = 1'h0;
  logic gr_n = 1'h1, br_n = 1'h1, cr_n = 1'h1, irq;
  logic [7:0] a = 8'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic [3:0] fd = 4'h0, ps;
  logic [8:0] tab [6] = '{9'h111, 9'h162, 9'h022, 9'h084, 9'h188, 9'h0E1};
  wire [4:0] pins;
  int miscompares = 0, n_checks = 0;
  always #25 clk = ~clk;
  card_model u_card (.pins_out(pins));
  socket_status_change_event_mask u_dut (
    .core_clk_in(clk), .rst_in(rst), .global_reset_n_in(gr_n), .bus_reset_n_in(br_n),
    .card_reset_n_in(cr_n), .pme_enable_in(pme), .socket_power_cycle_status_in(pins[3]),
    .card_detect_one_status_in(pins[1]), .card_detect_two_status_in(pins[2]),
    .card_status_change_state_in(pins[0]), .cardbus_card_in(pins[4]), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_addr_in(a), .reg_wdata_in(wd), .reg_rdata_out(rdat),
    .force_wr_in(fw), .force_data_in(fd), .irq_global_enable_in(ien),
    .present_state_out(ps), .status_change_interrupt_out(irq));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr_reg(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'h1; a <= ad; wd <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rd_reg(input logic [7:0] ad, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'h1; a <= ad;
    @(posedge clk);
    rd <= 1'h0;
    @(posedge clk);
    #1 chk($sformatf("reg %h", ad), e, rdat);
  endtask
  task automatic force_ev(input logic [3:0] f);
    @(posedge clk);
    fw <= 1'h1; fd <= f;
    @(posedge clk);
    fw <= 1'h0;
  endtask
  // 0 bus reset, 1 global reset, 2 card reset
  task automatic pin_pulse(input int w);
    @(posedge clk);
    if (w == 0) br_n <= 1'h0; else if (w == 1) gr_n <= 1'h0; else cr_n <= 1'h0;
    tick(4);
    br_n <= 1'h1; gr_n <= 1'h1; cr_n <= 1'h1;
    tick(6);
  endtask
  task automatic t_regs;
    rd_reg(8'h00, 32'h0);
    rd_reg(8'h04, 32'h0);
    wr_reg(8'h04, 32'hFFFFFFFF);
    rd_reg(8'h04, 32'hF);
    rd_reg(8'h08, 32'h0);
    wr_reg(8'h00, 32'hF);
    wr_reg(8'h04, 32'h0);
  endtask
  task automatic t_pins;
    for (int i = 1; i < 4; i++) begin
      u_card.drive(pins | (5'h01 << i));
      tick(6);
      rd_reg(8'h00, 32'h1 << i);
      chk("present", {28'h0, pins[3:0]}, {28'h0, ps});
      wr_reg(8'h00, 32'h0);
      rd_reg(8'h00, 32'h1 << i);
      wr_reg(8'h00, 32'h1 << i);
      rd_reg(8'h00, 32'h0);
    end
  endtask
  // status-change edges: first as a cardbus card, then as a 16-bit card
  task automatic t_sts;
    for (int k = 0; k < 2; k++) begin
      u_card.drive({!k[0], pins[3:1], 1'h1});
      tick(6);
      rd_reg(8'h00, 32'h1);
      wr_reg(8'h00, 32'h1);
      u_card.drive({!k[0], pins[3:1], 1'h0});
      tick(6);
      rd_reg(8'h00, {31'h0, k[0]});
      wr_reg(8'h00, 32'h1);
    end
  endtask
  // each entry is {expected interrupt, enables, forced bits}
  task automatic t_irq;
    ien <= 1'h1;
    foreach (tab[j]) begin
      wr_reg(8'h00, 32'hF);
      force_ev(tab[j][3:0]);
      wr_reg(8'h04, {28'h0, tab[j][7:4]});
      tick(2);
      #1 chk("irq", tab[j][8], irq);
    end
    ien <= 1'h0;
    tick(2);
    #1 chk("irq", 1'h0, irq);
  endtask
  task automatic t_resets;
    u_card.drive({1'h1, pins[3:0]});
    wr_reg(8'h04, 32'hF);
    pme <= 1'h1;
    pin_pulse(0);
    rd_reg(8'h00, 32'h1);
    rd_reg(8'h04, 32'hF);
    pme <= 1'h0;
    pin_pulse(0);
    rd_reg(8'h00, 32'h0);
    rd_reg(8'h04, 32'h0);
    force_ev(4'h1);
    pme <= 1'h1;
    pin_pulse(1);
    rd_reg(8'h00, 32'h0);
    pin_pulse(2);
    rd_reg(8'h00, 32'h6);
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    tick(2);
    rst <= 1'h0;
    t_regs();
    t_pins();
    t_sts();
    t_irq();
    t_resets();
    end_of_test();
  end
  initial begin
    tick(5000);
    miscompares++;
    end_of_test();
  end
endmodule // socket_status_change_event_mask_bench
`default_nettype wire
